// [logic/i2ctp_sync.sv]
// two-flop synchroniser for the bus lines and strap
`timescale 1ns/1ps
module i2ctp_sync
   import i2ctp_pkg::*;
#(
   parameter int WIDTH = 4
) (
   // clock and reset
   input  logic             i_clk,
   input  logic             i_rst,
   // asynchronous inputs and their synchronised copies
   input  logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // idle bus reads high, so reset to ones
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_ff <= '1;
         sync_ff <= '1;
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end

   assign o_sync = sync_ff;

endmodule : i2ctp_sync

// [logic/i2ctp_target.sv]
// two-wire target port with byte-wide register file
//
// Overview of operation
// - chip select high enables the port; only clock and data lines are used.
// - bus edges found by oversampling; 100 and 400 kHz both fit easily.
// - strap high: answer address 0x1D, bytes 0x3A write and 0x3B read.
// - strap low: answer address 0x53, bytes 0xA6 write and 0xA7 read.
// - write: acknowledge address, register pointer and every data byte.
// - read after restart: acknowledge address, send bytes until controller nacks.
`timescale 1ns/1ps
module i2ctp_target
   import i2ctp_pkg::*;
#(
   parameter int REG_DEPTH = I2CTP_REG_DEPTH
) (
   // clock and reset
   input  logic       i_clk,
   input  logic       i_rst,
   // chip select and address strap pins
   input  logic       i_chip_sel,
   input  logic       i_bus_address_strap,
   // serial clock from the controller
   input  logic       i_scl,
   // serial data, open drain
   input  logic       i_sda,
   output logic       o_sda,
   output logic       o_sda_oe_n,
   // status toward the sensor core
   output logic       o_wr_en,
   output logic [5:0] o_wr_addr,
   output logic [7:0] o_wr_data,
   output logic       o_busy
);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisation

   logic [3:0]      sync_w;
   i2ctp_bus_type   bus_w;
   logic            cs_w;
   logic            strap_w;

   i2ctp_sync #(
      .WIDTH (4)
   ) u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async ({i_chip_sel, i_bus_address_strap, i_scl, i_sda}),
      .o_sync  (sync_w)
   );

   assign cs_w      = sync_w[3];
   assign strap_w   = sync_w[2];
   assign bus_w.scl = sync_w[1];
   assign bus_w.sda = sync_w[0];

   ////////////////////////////////////////////////////////////////////////
   // edge and condition detection

   i2ctp_bus_type bus_ff;
   logic          scl_rise;
   logic          scl_fall;
   logic          start_det;
   logic          stop_det;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         bus_ff <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         bus_ff <= bus_w;
      end
   end

   // 20 MHz sampling gives many samples per fast-mode bit
   assign scl_rise  = cs_w & bus_w.scl & ~bus_ff.scl;
   assign scl_fall  = cs_w & ~bus_w.scl & bus_ff.scl;
   assign start_det = cs_w & bus_w.scl & bus_ff.scl
                      & bus_ff.sda & ~bus_w.sda;
   assign stop_det  = bus_w.scl & bus_ff.scl & ~bus_ff.sda & bus_w.sda;

   ////////////////////////////////////////////////////////////////////////
   // address match

   function automatic logic addr_match(input logic [7:0] b,
                                       input logic       strap);
      logic [6:0] own;
      own = strap ? I2CTP_ADDR_STRAP_HI : I2CTP_ADDR_STRAP_LO;
      return b[7:1] == own;
   endfunction : addr_match

   ////////////////////////////////////////////////////////////////////////
   // byte engine

   i2ctp_state_type state_ff;
   logic [3:0]      bit_ff;
   logic [7:0]      shift_ff;
   logic [7:0]      ptr_ff;
   logic            sda_low_ff;
   logic            nack_ff;
   i2ctp_wr_type    wr_ff;
   logic [7:0]      regs [REG_DEPTH];
   logic [7:0]      rd_byte;
   logic [7:0]      rx_byte;

   assign rx_byte = {shift_ff[6:0], bus_w.sda};
   assign rd_byte = regs[ptr_ff[I2CTP_REG_AW-1:0]];

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_ff <= I2CTP_IDLE;
         bit_ff   <= I2CTP_BIT_ZERO;
         shift_ff <= 8'h00;
         nack_ff  <= 1'b0;
      end else if (!cs_w || stop_det) begin
         state_ff <= I2CTP_IDLE;
      end else if (start_det) begin
         // repeated start keeps the pointer for the read that follows
         state_ff <= I2CTP_ADDR;
         bit_ff   <= I2CTP_BIT_ZERO;
      end else if (scl_rise) begin
         unique case (state_ff)
            I2CTP_ADDR, I2CTP_PTR, I2CTP_WDATA: begin
               shift_ff <= rx_byte;
               bit_ff   <= bit_ff + 4'h1;
            end
            I2CTP_RDATA_ACK: begin
               nack_ff <= bus_w.sda;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (state_ff)
            I2CTP_IDLE: begin
            end
            I2CTP_ADDR: begin
               if (bit_ff == I2CTP_BIT_LAST + 4'h1) begin
                  state_ff <= addr_match(shift_ff, strap_w)
                              ? I2CTP_ADDR_ACK : I2CTP_IDLE;
               end
            end
            I2CTP_ADDR_ACK: begin
               bit_ff   <= I2CTP_BIT_ZERO;
               state_ff <= shift_ff[I2CTP_RW_POS]
                           ? I2CTP_RDATA : I2CTP_PTR;
            end
            I2CTP_PTR: begin
               if (bit_ff == I2CTP_BIT_LAST + 4'h1) begin
                  state_ff <= I2CTP_PTR_ACK;
               end
            end
            I2CTP_PTR_ACK, I2CTP_WDATA_ACK: begin
               bit_ff   <= I2CTP_BIT_ZERO;
               state_ff <= I2CTP_WDATA;
            end
            I2CTP_WDATA: begin
               if (bit_ff == I2CTP_BIT_LAST + 4'h1) begin
                  state_ff <= I2CTP_WDATA_ACK;
               end
            end
            I2CTP_RDATA: begin
               if (bit_ff == I2CTP_BIT_LAST) begin
                  state_ff <= I2CTP_RDATA_ACK;
               end
               bit_ff <= bit_ff + 4'h1;
            end
            I2CTP_RDATA_ACK: begin
               bit_ff   <= I2CTP_BIT_ZERO;
               // a nack ends the read; the line is left free for stop
               state_ff <= nack_ff ? I2CTP_IDLE : I2CTP_RDATA;
            end
         endcase
      end
   end

   // register pointer
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ptr_ff <= I2CTP_PTR_RESET;
      end else if (scl_fall && state_ff == I2CTP_PTR_ACK) begin
         ptr_ff <= shift_ff;
      end else if (scl_fall && (state_ff == I2CTP_WDATA_ACK
                   || state_ff == I2CTP_RDATA_ACK)) begin
         ptr_ff <= ptr_ff + 8'h01;
      end
   end

   // register file write, taken as the data byte is acknowledged
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_ff <= '0;
      end else begin
         wr_ff.en <= scl_fall && state_ff == I2CTP_WDATA
                     && bit_ff == I2CTP_BIT_LAST + 4'h1;
         wr_ff.addr <= ptr_ff[I2CTP_REG_AW-1:0];
         wr_ff.data <= shift_ff;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < REG_DEPTH; i++) begin
            regs[i] <= I2CTP_REG_RESET;
         end
      end else if (wr_ff.en) begin
         regs[wr_ff.addr] <= wr_ff.data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data line drive, changed only while the clock is low

   always_ff @(posedge i_clk) begin
      if (i_rst || !cs_w || stop_det || start_det) begin
         sda_low_ff <= 1'b0;
      end else if (scl_fall) begin
         unique case (state_ff)
            I2CTP_ADDR, I2CTP_PTR, I2CTP_WDATA: begin
               // ack after the eighth bit, only for our own address
               sda_low_ff <= (bit_ff == I2CTP_BIT_LAST + 4'h1)
                  && (state_ff != I2CTP_ADDR
                      || addr_match(shift_ff, strap_w));
            end
            I2CTP_ADDR_ACK: begin
               sda_low_ff <= shift_ff[I2CTP_RW_POS]
                             && !rd_byte[7];
            end
            I2CTP_RDATA: begin
               // after bit 7 release the line for the controller's ack
               sda_low_ff <= (bit_ff != I2CTP_BIT_LAST)
                             && !rd_byte[3'(6 - bit_ff)];
            end
            I2CTP_RDATA_ACK: begin
               sda_low_ff <= !nack_ff && !regs[6'(ptr_ff + 8'h01)][7];
            end
            default: begin
               sda_low_ff <= 1'b0;
            end
         endcase
      end
   end

   assign o_sda      = 1'b0;
   assign o_sda_oe_n = ~sda_low_ff;
   assign o_wr_en    = wr_ff.en;
   assign o_wr_addr  = wr_ff.addr;
   assign o_wr_data  = wr_ff.data;
   assign o_busy     = state_ff != I2CTP_IDLE;

endmodule : i2ctp_target

// [shared/i2ctp_pkg.sv]
// shared constants and types for the two-wire target register port
package i2ctp_pkg;

   // bus addresses chosen by the strap pin
   localparam logic [6:0] I2CTP_ADDR_STRAP_HI = 7'h1D;
   localparam logic [6:0] I2CTP_ADDR_STRAP_LO = 7'h53;

   // register space
   localparam int         I2CTP_REG_AW        = 6;
   localparam int         I2CTP_REG_DEPTH     = 64;
   localparam logic [7:0] I2CTP_REG_RESET     = 8'h00;
   localparam logic [7:0] I2CTP_PTR_RESET     = 8'h00;

   // bit counting within a byte
   localparam logic [3:0] I2CTP_BIT_LAST      = 4'h7;
   localparam logic [3:0] I2CTP_BIT_ZERO      = 4'h0;
   localparam int         I2CTP_RW_POS        = 0;

   // sampling clock and bus clock periods the port is built for, in ns
   localparam int I2CTP_CLK_NS      = 50;
   localparam int I2CTP_SCL_FAST_NS = 2500;
   localparam int I2CTP_SCL_STD_NS  = 10000;
   localparam int I2CTP_SCL_FAST_CYC = I2CTP_SCL_FAST_NS / I2CTP_CLK_NS;

   // sampled bus lines
   typedef struct packed {
      logic scl;
      logic sda;
   } i2ctp_bus_type;

   // register write request toward the register file
   typedef struct packed {
      logic                    en;
      logic [I2CTP_REG_AW-1:0] addr;
      logic [7:0]              data;
   } i2ctp_wr_type;

   typedef enum {
      I2CTP_IDLE,
      I2CTP_ADDR,
      I2CTP_ADDR_ACK,
      I2CTP_PTR,
      I2CTP_PTR_ACK,
      I2CTP_WDATA,
      I2CTP_WDATA_ACK,
      I2CTP_RDATA,
      I2CTP_RDATA_ACK
   } i2ctp_state_type;

endpackage : i2ctp_pkg

// [verification/i2ctp_ctrl_model.sv]
// behavioural two-wire bus controller
`timescale 1ns/1ps
module i2ctp_ctrl_model (
   // bus clock and open-drain data pull
   output logic o_scl,
   output logic o_sda_pull,
   // wired data level
   input  logic i_sda
);
   // low phase outlasts the port's answer delay of 2-3 clocks
   localparam time LO = 250ns;
   localparam time HI = 150ns;
   initial begin
      o_scl = 1'h1;
      o_sda_pull = 1'h0;
   end
   task automatic bit_io(input logic b, output logic r);
      o_sda_pull = !b;
      #LO o_scl = 1'h1;
      #HI r = i_sda;
      o_scl = 1'h0;
   endtask : bit_io
   // reading: b all ones, ack low to acknowledge
   task automatic xfer(input logic [7:0] b, input logic ack,
                       output logic [7:0] r, output logic ak);
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r[i]);
      end
      bit_io(ack, ak);
   endtask : xfer
   task automatic start;
      #LO o_sda_pull = 1'h0;
      #LO o_scl = 1'h1;
      #HI o_sda_pull = 1'h1;
      #HI o_scl = 1'h0;
   endtask : start
   task automatic stop;
      o_sda_pull = 1'h1;
      #LO o_scl = 1'h1;
      #HI o_sda_pull = 1'h0;
      #LO;
   endtask : stop
endmodule : i2ctp_ctrl_model

// [verification/i2ctp_monitor.sv]
// checker for the two-wire target port
`timescale 1ns/1ps
module i2ctp_monitor #(
   parameter int REG_DEPTH = 64
) (
   // watched ports
   input logic       i_clk,
   input logic       i_rst,
   input logic       i_chip_sel,
   input logic       i_scl,
   input logic       o_sda,
   input logic       o_sda_oe_n,
   input logic       o_wr_en,
   input logic [5:0] o_wr_addr,
   input logic       o_busy
);
   logic [5:0] last_ff;
   logic       seen_ff;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////
   // seen_ff: a byte was already written in this transfer
   always_ff @(posedge i_clk) begin
      seen_ff <= o_busy && (seen_ff || o_wr_en);
      last_ff <= o_wr_en ? o_wr_addr : last_ff;
   end
   sda_const_a: assert property (o_sda == 1'h0)
      else $error("sda output not low");
   reset_idle_a: assert property ($fell(i_rst) |-> o_sda_oe_n && !o_busy)
      else $error("not idle after reset");
   cs_idle_a: assert property (
      (!i_chip_sel)[*6] |-> o_sda_oe_n && !o_busy)
      else $error("active while deselected");
   wr_pulse_a: assert property (o_wr_en |=> !o_wr_en)
      else $error("write pulse too long");
   wr_busy_a: assert property (o_wr_en |-> o_busy)
      else $error("write outside transfer");
   ptr_step_a: assert property (
      o_wr_en && seen_ff |-> o_wr_addr == last_ff + 6'h01)
      else $error("pointer did not step");
   // drive may only move while the bus clock is low; a bit's high phase
   // spans only three samples, so two in a row must already hold it
   drive_hold_a: assert property (i_scl[*2] |-> $stable(o_sda_oe_n))
      else $error("data drive moved in clock high");
endmodule : i2ctp_monitor

bind i2ctp_target i2ctp_monitor #(.REG_DEPTH(REG_DEPTH)) mon_u (
   .i_clk(i_clk), .i_rst(i_rst), .i_chip_sel(i_chip_sel), .i_scl(i_scl),
   .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_wr_en(o_wr_en),
   .o_wr_addr(o_wr_addr), .o_busy(o_busy));

// [verification/tb_i2c_target_register_port.sv]
// self-checking bench for the two-wire target port
`timescale 1ns/1ps
module tb_i2c_target_register_port;
   logic        clk, rst, cs, strap, scl, pull, oe_n, sda_o, wr_en, busy, ak;
   logic [5:0]  wr_addr;
   logic [7:0]  wr_data, rd, d0, d1;
   logic [13:0] e;
   logic [13:0] exp_q[$];
   int          n_errors = 0;
   int          cmp_count = 0;
   wire         sda = !pull && (oe_n || sda_o);
   i2ctp_target #(.REG_DEPTH(64)) dut_u (
      .i_clk(clk), .i_rst(rst), .i_chip_sel(cs), .i_bus_address_strap(strap),
      .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe_n(oe_n),
      .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
      .o_busy(busy));
   i2ctp_ctrl_model ctl_u (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));
   initial begin
      clk = 1'h0;
      forever #25 clk = !clk;
   end
   ////////////////////////////////////////
   function automatic bit ok(input bit c);
      cmp_count++;
      return c;
   endfunction : ok
   task automatic err(input string m);
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
   endtask : err
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   // lvl: expected wire level in the acknowledge slot
   // w[14] marks a byte that must reach the register file as w[13:0]
   task automatic send(input logic [7:0]  b,
                       input logic        lvl,
                       input logic [14:0] w);
      if (w[14]) exp_q.push_back(w[13:0]);
      ctl_u.xfer(b, 1'h1, rd, ak);
      if (!ok(ak === lvl)) err("ack slot");
   endtask : send
   task automatic recv(input logic [7:0] x, input logic nak);
      ctl_u.xfer(8'hFF, nak, rd, ak);
      if (!ok(rd === x)) err("read data");
   endtask : recv
   task automatic pins(input logic c, input logic s);
      @(posedge clk);
      #5;
      cs = c;
      strap = s;
      repeat (8) @(posedge clk);
      // keeps every controller edge off the sampling edge
      #5;
   endtask : pins
   // each write pulse takes the oldest note
   always @(negedge clk) begin
      if (wr_en === 1'h1) begin
         if (!ok(exp_q.size() != 0)) begin
            err("unexpected write");
         end else begin
            e = exp_q.pop_front();
            if (!ok({wr_addr, wr_data} === e)) err("register write");
         end
      end
   end
   initial begin
      rst = 1'h1;
      cs = 1'h1;
      strap = 1'h1;
      void'($urandom(2));
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      repeat (4) @(posedge clk);
      #5;
      rst = 1'h0;
      pins(1'h1, 1'h1);
      ctl_u.start;
      send(8'h3A, 1'h0, 15'h0);
      send(8'h05, 1'h0, 15'h0);
      send(d0, 1'h0, {1'h1, 6'h05, d0});
      send(d1, 1'h0, {1'h1, 6'h06, d1});
      ctl_u.stop;
      $display("burst write done");
      ctl_u.start;
      send(8'h3A, 1'h0, 15'h0);
      send(8'h05, 1'h0, 15'h0);
      ctl_u.start;
      send(8'h3B, 1'h0, 15'h0);
      recv(d0, 1'h0);
      recv(d1, 1'h1);
      ctl_u.stop;
      ctl_u.start;
      send(8'hA6, 1'h1, 15'h0);
      ctl_u.stop;
      $display("read and refusal done");
      pins(1'h1, 1'h0);
      ctl_u.start;
      send(8'hA6, 1'h0, 15'h0);
      send(8'h3F, 1'h0, 15'h0);
      send(d1, 1'h0, {1'h1, 6'h3F, d1});
      send(d0, 1'h0, {1'h1, 6'h00, d0});
      ctl_u.stop;
      ctl_u.start;
      send(8'hA6, 1'h0, 15'h0);
      send(8'h3F, 1'h0, 15'h0);
      ctl_u.stop;
      ctl_u.start;
      send(8'hA7, 1'h0, 15'h0);
      recv(d1, 1'h0);
      recv(d0, 1'h1);
      ctl_u.stop;
      pins(1'h0, 1'h0);
      ctl_u.start;
      send(8'hA6, 1'h1, 15'h0);
      ctl_u.stop;
      pins(1'h1, 1'h0);
      if (!ok(exp_q.size() == 0)) err("missing write");
      $display("alternate address and deselect done");
      stop_test;
   end
   initial begin
      #1ms;
      err("timeout");
      stop_test;
   end
endmodule : tb_i2c_target_register_port
